// ---- verif/cpu_core_model.sv ----
`timescale 1ns/10ps
// cpu core stand-in: bus cycles, fetches and data accesses
module cpu_core_model
(
   // clock
   input wire logic clk,
   // register bus
   output logic [15:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic bus_bitop,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   // monitored activity
   output logic fetch_valid,
   output logic [15:0] fetch_addr,
   output logic access_valid,
   output logic [15:0] access_addr,
   output logic [15:0] rom_end,
   output logic [15:0] ram_start
);
   // idle at time zero; memory size fixed for the run
   initial
   begin
      bus_addr = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_bitop = 1'b0;
      bus_wdata = 8'h00;
      fetch_valid = 1'b0;
      fetch_addr = 16'h0000;
      access_valid = 1'b0;
      access_addr = 16'h0000;
      rom_end = 16'h8000;
      ram_start = 16'hfc00;
   end
   // one write; released bus shows inverted values
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b1);
   begin
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_bitop <= b1;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_bitop <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
   end
   endtask
   // one read; data taken on the falling edge after the next rising edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
   begin
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      @(negedge clk);
      d = bus_rdata;
      @(posedge clk);
   end
   endtask
   // one-cycle fetch or data access
   task automatic touch(input logic f, input logic [15:0] a);
   begin
      @(posedge clk);
      fetch_valid <= f;
      access_valid <= !f;
      fetch_addr <= a;
      access_addr <= a;
      @(posedge clk);
      fetch_valid <= 1'b0;
      access_valid <= 1'b0;
   end
   endtask
endmodule

// ---- verif/test_windowed_watchdog_timer.sv ----
`timescale 1ns/10ps
// self-checking bench for the windowed watchdog
module test_windowed_watchdog_timer;
   localparam logic [15:0] sa = wdt_pkg::SERVICE_ADDR;
   localparam logic [7:0] sc = wdt_pkg::SERVICE_CODE;
   logic clk, rst, en, lock, halt, stp, ostop, clr, ires, bus_wr, bus_rd, bus_bitop;
   logic fetch_valid, access_valid;
   logic [1:0] win;
   logic [2:0] ovf;
   logic [7:0] cause, rdata, bus_wdata, bus_rdata;
   logic [15:0] bus_addr, fetch_addr, access_addr, rom_end, ram_start;
   int n_errors = 0;
   int check_count = 0;
   // design with a short low-speed divider
   windowed_watchdog_timer #(.DIVIDE(4)) u_windowed_watchdog_timer
   (
      .CLK(clk), .RST(rst), .WINDOW_SELECT(win), .COUNT_ENABLE_OPTION(en),
      .OVERFLOW_SELECT(ovf), .OSCILLATOR_LOCK_OPTION(lock), .HALT_MODE(halt),
      .STOP_MODE(stp), .LOWSPEED_OSC_STOP_BIT(ostop), .BUS_ADDR(bus_addr),
      .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_BITOP(bus_bitop), .BUS_WDATA(bus_wdata),
      .BUS_RDATA(bus_rdata), .FETCH_VALID(fetch_valid), .FETCH_ADDR(fetch_addr),
      .ACCESS_VALID(access_valid), .ACCESS_ADDR(access_addr),
      .MEM_SIZE_ROM_END(rom_end), .MEM_SIZE_RAM_START(ram_start),
      .INTERNAL_RESET(ires), .RESET_CAUSE_CLEAR(clr), .RESET_CAUSE_REG(cause)
   );
   // cpu side
   cpu_core_model u_cpu_core_model
   (
      .clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_bitop(bus_bitop), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .access_valid(access_valid),
      .access_addr(access_addr), .rom_end(rom_end), .ram_start(ram_start)
   );
   // 40 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task automatic chk_res(input logic e);
   begin
      chk({7'h00, ires}, {7'h00, e});
   end
   endtask
   task automatic ticks(input int n);
   begin
      repeat (n * 4) @(posedge clk);
   end
   endtask
   task automatic do_reset;
   begin
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   end
   endtask
   task automatic svc(input logic [7:0] d, input logic b1);
   begin
      u_cpu_core_model.wr(sa, d, b1);
      repeat (3) @(posedge clk);
   end
   endtask
   // reset values, read-back, disabled watchdog
   task automatic t_regs;
   begin
      ovf <= 3'h0;
      do_reset;
      chk(cause, 8'h00);
      u_cpu_core_model.rd(sa, rdata);
      chk(rdata, 8'h9a);
      svc(sc, 1'b0);
      u_cpu_core_model.rd(sa, rdata);
      chk(rdata, 8'h9a);
      u_cpu_core_model.rd(16'hff98, rdata);
      chk(rdata, 8'h00);
      en <= 1'b0;
      do_reset;
      u_cpu_core_model.rd(sa, rdata);
      chk(rdata, 8'h1a);
      svc(8'h55, 1'b0);
      u_cpu_core_model.touch(1'b1, 16'h9000);
      ticks(1100);
      chk_res(1'b0);
      en <= 1'b1;
   end
   endtask
   // bad value, bit instruction, fault with stopped source
   task automatic t_faults;
   begin
      for (int k = 0; k < 2; k++)
      begin
         do_reset;
         svc((k == 1) ? sc : 8'h55, 1'(k));
         chk_res(1'b1);
         chk(cause, 8'h10);
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         @(posedge clk);
         chk(cause, 8'h00);
      end
      ostop <= 1'b1;
      do_reset;
      svc(8'h55, 1'b0);
      repeat (20) @(posedge clk);
      chk_res(1'b0);
      ostop <= 1'b0;
      repeat (20) @(posedge clk);
      chk_res(1'b1);
   end
   endtask
   // fetch and data access monitoring
   task automatic t_access;
   begin
      do_reset;
      u_cpu_core_model.touch(1'b1, 16'h1000);
      u_cpu_core_model.touch(1'b0, 16'hfd00);
      u_cpu_core_model.touch(1'b0, 16'hfb10);
      u_cpu_core_model.touch(1'b0, 16'hfff0);
      repeat (2) @(posedge clk);
      chk_res(1'b0);
      u_cpu_core_model.touch(1'b0, 16'h9000);
      repeat (2) @(posedge clk);
      chk_res(1'b1);
      do_reset;
      u_cpu_core_model.touch(1'b1, 16'hfb10);
      repeat (2) @(posedge clk);
      chk_res(1'b1);
   end
   endtask
   // overflow interval for select codes 0 to 2
   task automatic t_overflow;
   begin
      for (int c = 0; c < 3; c++)
      begin
         win <= 2'h3;
         ovf <= 3'(c);
         do_reset;
         ticks((1 << (10 + c)) - 3);
         chk_res(1'b0);
         ticks(6);
         chk_res(1'b1);
      end
   end
   endtask
   // second service just before and just after the window opens
   task automatic t_window;
      int b;
   begin
      for (int w = 0; w < 4; w++)
      begin
         for (int k = 0; k < 2; k++)
         begin
            b = 512 * (3 - w);
            win <= 2'(w);
            ovf <= 3'h1;
            do_reset;
            ticks(10);
            svc(sc, 1'b0);
            ticks((k == 1) ? b + 40 : ((b > 40) ? b - 40 : 5));
            svc(sc, 1'b0);
            chk_res(k == 0 && b > 0);
            if (k == 1 && w == 0)
            begin
               ticks(2040);
               svc(sc, 1'b0);
               chk_res(1'b0);
            end
         end
      end
   end
   endtask
   // halt pauses and resumes; lock keeps counting
   task automatic t_halt;
   begin
      win <= 2'h3;
      ovf <= 3'h0;
      do_reset;
      ticks(500);
      halt <= 1'b1;
      ticks(1000);
      chk_res(1'b0);
      halt <= 1'b0;
      ticks(600);
      chk_res(1'b1);
      lock <= 1'b1;
      do_reset;
      ticks(500);
      stp <= 1'b1;
      ticks(600);
      chk_res(1'b1);
      stp <= 1'b0;
      lock <= 1'b0;
   end
   endtask
   task automatic give_verdict;
   begin
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   // hang guard
   initial
   begin
      repeat (95000) @(posedge clk);
      n_errors++;
      give_verdict;
   end
   // main sequence
   initial
   begin
      rst = 1'b1;
      win = 2'h3;
      en = 1'b1;
      ovf = 3'h1;
      lock = 1'b0;
      halt = 1'b0;
      stp = 1'b0;
      ostop = 1'b0;
      clr = 1'b0;
      t_regs;
      t_faults;
      t_access;
      t_overflow;
      t_window;
      t_halt;
      give_verdict;
   end
endmodule

// ---- verilog/access_checker.sv ----
`timescale 1ns/10ps
// flags fetches and data accesses outside the configured memory
module access_checker
(
   // monitored cpu activity
   cpu_watch_if.monitor watch
);
   logic fetch_ok;
   logic data_ok;

   // legal areas: internal rom below rom_end, ram from ram_start
   always_comb
   begin
      fetch_ok = (watch.fetch_addr < watch.rom_end) ||
                 (watch.fetch_addr >= watch.ram_start && watch.fetch_addr <= wdt_pkg::RAM_TOP);
      data_ok = (watch.access_addr < watch.rom_end) ||
                (watch.access_addr >= watch.ram_start &&
                 watch.access_addr < wdt_pkg::EXEMPT_A_LO) ||
                (watch.access_addr <= wdt_pkg::EXEMPT_A_HI &&
                 watch.access_addr >= wdt_pkg::EXEMPT_A_LO) ||
                (watch.access_addr >= wdt_pkg::EXEMPT_B_LO);
   end

   // fault is combinational; the top gates it with the enable
   assign watch.fault = (watch.fetch_valid && !fetch_ok) ||
                        (watch.access_valid && !data_ok);
endmodule

// ---- verilog/cpu_watch_if.sv ----
`timescale 1ns/10ps
// cpu fetch and data access monitor bundle
interface cpu_watch_if;
   logic fetch_valid;
   logic [15:0] fetch_addr;
   logic access_valid;
   logic [15:0] access_addr;
   logic [15:0] rom_end;
   logic [15:0] ram_start;
   logic fault;
   modport source (output fetch_valid, fetch_addr, access_valid, access_addr,
                   rom_end, ram_start, input fault);
   modport monitor (input fetch_valid, fetch_addr, access_valid, access_addr,
                    rom_end, ram_start, output fault);
endinterface

// ---- verilog/lowspeed_divider.sv ----
`timescale 1ns/10ps
// one-cycle tick at the low-speed oscillator rate
module lowspeed_divider
#(
   parameter int DIVIDE = wdt_pkg::LOWSPEED_DIVIDE
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic run,
   // tick out
   output logic tick
);
   logic [15:0] phase;

   // phase held while stopped so the count is not disturbed
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         phase <= 16'h0000;
         tick <= 1'b0;
      end
      else if (run)
      begin
         if (phase == 16'(DIVIDE - 1))
         begin
            phase <= 16'h0000;
            tick <= 1'b1;
         end
         else
         begin
            phase <= phase + 16'h0001;
            tick <= 1'b0;
         end
      end
      else
         tick <= 1'b0;
   end

   // no tick in the cycle after a stopped cycle
   stop_no_tick_a: assert property (@(posedge clk) disable iff (rst)
      !run |=> !tick)
      else $error("tick while divider stopped");
endmodule

// ---- verilog/wdt_pkg.sv ----
//
// Operation
// - counter advances on low-speed oscillator ticks
// - overflow select picks 2^10..2^17 ticks
// - service code write clears counter
// - other written value raises internal reset
// - bit instruction on service register faults
// - fault waits for stopped source clock
// - reads return reset value, not code
// - reset value 9a enabled, 1a disabled
// - enable option gates counting and detection
// - window select taken from option bits
// - first service ignores window before overflow
// - later service in closed window faults
// - fetch outside memory setting raises reset
// - data access outside area faults, exemptions
// - watchdog reset sets cause flag bit
// - clear jitter at most two ticks
// - service accepted up to last count
// - halt/stop pause counting unless locked
// - paused counter resumes from held value
// - oscillator stop halts without clearing count
// - window codes give 25/50/75/100 percent
//
package wdt_pkg;
   // ------------------------------------------------------------
   // clock and low-speed tick
   // ------------------------------------------------------------
   localparam int CLK_FREQ_HZ = 40000000;
   localparam int LOWSPEED_CLOCK_FREQ_HZ = 264000;
   localparam int LOWSPEED_DIVIDE = CLK_FREQ_HZ / LOWSPEED_CLOCK_FREQ_HZ;
   // ------------------------------------------------------------
   // service register
   // ------------------------------------------------------------
   localparam logic [15:0] SERVICE_ADDR = 16'hff99;
   localparam logic [7:0] SERVICE_CODE = 8'hac;
   localparam logic [7:0] SERVICE_RESET_ENABLED = 8'h9a;
   localparam logic [7:0] SERVICE_RESET_DISABLED = 8'h1a;
   // ------------------------------------------------------------
   // counter and window
   // ------------------------------------------------------------
   localparam int COUNT_W = 18;
   localparam logic [17:0] OVERFLOW_BASE = 18'h00400;
   localparam logic [17:0] WINDOW_QUARTER_BASE = 18'h00100;
   localparam logic [1:0] WINDOW_CLOSED_QUARTERS = 2'h3;
   // ------------------------------------------------------------
   // address areas
   // ------------------------------------------------------------
   localparam logic [15:0] RAM_TOP = 16'hfeff;
   localparam logic [15:0] EXEMPT_A_LO = 16'hfb00;
   localparam logic [15:0] EXEMPT_A_HI = 16'hffcf;
   localparam logic [15:0] EXEMPT_B_LO = 16'hffe0;
   // ------------------------------------------------------------
   // reset cause
   // ------------------------------------------------------------
   localparam int RESET_CAUSE_WDT_BIT = 4;
endpackage

// ---- verilog/windowed_watchdog_timer.sv ----
`timescale 1ns/10ps
// windowed watchdog: low-speed counter, service register, access monitor
module windowed_watchdog_timer
#(
   parameter int DIVIDE = wdt_pkg::LOWSPEED_DIVIDE
)
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // option byte fields
   input wire logic [1:0] WINDOW_SELECT,
   input wire logic COUNT_ENABLE_OPTION,
   input wire logic [2:0] OVERFLOW_SELECT,
   input wire logic OSCILLATOR_LOCK_OPTION,
   // power modes and oscillator control
   input wire logic HALT_MODE,
   input wire logic STOP_MODE,
   input wire logic LOWSPEED_OSC_STOP_BIT,
   // cpu register bus
   input wire logic [15:0] BUS_ADDR,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   input wire logic BUS_BITOP,
   input wire logic [7:0] BUS_WDATA,
   output logic [7:0] BUS_RDATA,
   // cpu fetch and access monitor
   input wire logic FETCH_VALID,
   input wire logic [15:0] FETCH_ADDR,
   input wire logic ACCESS_VALID,
   input wire logic [15:0] ACCESS_ADDR,
   input wire logic [15:0] MEM_SIZE_ROM_END,
   input wire logic [15:0] MEM_SIZE_RAM_START,
   // reset outputs and cause clear input
   output logic INTERNAL_RESET,
   input wire logic RESET_CAUSE_CLEAR,
   output logic [7:0] RESET_CAUSE_REG
);
   logic enabled;
   logic tick;
   logic source_stopped;
   logic [17:0] count;
   logic [17:0] last_count;
   logic [17:0] closed_end;
   logic window_closed;
   logic first_done;
   logic svc_hit;
   logic svc_fault;
   logic svc_ok;
   logic access_fault;
   logic overflow;
   logic fault_now;
   logic pending;
   logic fire;
   logic watchdog_reset_flag;

   cpu_watch_if watch ();

   // ------------------------------------------------------------
   // option capture and clock source
   // ------------------------------------------------------------

   // enable option caught after release, never under reset
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         enabled <= 1'b0;
      else
         enabled <= COUNT_ENABLE_OPTION;
   end

   // low-speed source pauses in halt/stop or when stopped, unless locked on
   assign source_stopped = !OSCILLATOR_LOCK_OPTION &&
                           (HALT_MODE || STOP_MODE || LOWSPEED_OSC_STOP_BIT);

   lowspeed_divider #(
      .DIVIDE(DIVIDE)
   ) u_div (
      .clk(CLK),
      .rst(RST),
      .run(enabled && !source_stopped),
      .tick(tick)
   );

   // ------------------------------------------------------------
   // access monitor
   // ------------------------------------------------------------

   // drive the monitor bundle from the cpu pins
   assign watch.fetch_valid = FETCH_VALID;
   assign watch.fetch_addr = FETCH_ADDR;
   assign watch.access_valid = ACCESS_VALID;
   assign watch.access_addr = ACCESS_ADDR;
   assign watch.rom_end = MEM_SIZE_ROM_END;
   assign watch.ram_start = MEM_SIZE_RAM_START;

   access_checker u_chk (
      .watch(watch)
   );

   assign access_fault = enabled && watch.fault;

   // ------------------------------------------------------------
   // interval and window
   // ------------------------------------------------------------

   // last count before overflow and end of closed window
   always_comb
   begin
      last_count = (wdt_pkg::OVERFLOW_BASE << OVERFLOW_SELECT) - 18'h00001;
      closed_end = 18'((wdt_pkg::WINDOW_QUARTER_BASE << OVERFLOW_SELECT) *
                       {16'h0000,
                        2'(wdt_pkg::WINDOW_CLOSED_QUARTERS - WINDOW_SELECT)});
      window_closed = (count < closed_end);
   end

   // ------------------------------------------------------------
   // service register decode
   // ------------------------------------------------------------

   // classify writes to the service register
   always_comb
   begin
      svc_hit = enabled && BUS_WR && (BUS_ADDR == wdt_pkg::SERVICE_ADDR);
      svc_fault = svc_hit && (BUS_BITOP ||
                  (BUS_WDATA != wdt_pkg::SERVICE_CODE) ||
                  (first_done && window_closed));
      svc_ok = svc_hit && !svc_fault;
   end

   // overflow when the last count ticks on without service
   assign overflow = enabled && tick && (count == last_count) && !svc_ok;
   assign fault_now = svc_fault || access_fault;
   assign fire = overflow || (fault_now && !source_stopped) || (pending && tick);

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------

   // cleared by service, advanced by ticks, held while paused
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         count <= 18'h00000;
      else if (svc_ok)
         count <= 18'h00000;
      else if (tick)
      begin
         if (count == last_count)
            count <= 18'h00000;
         else
            count <= count + 18'h00001;
      end
   end

   // first accepted service opens window checking
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         first_done <= 1'b0;
      else if (svc_ok)
         first_done <= 1'b1;
   end

   // ------------------------------------------------------------
   // reset generation
   // ------------------------------------------------------------

   // fault seen while the source is stopped waits for its next tick
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         pending <= 1'b0;
      else if (fault_now && source_stopped)
         pending <= 1'b1;
   end

   // internal reset stays until the system reset answers it
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         INTERNAL_RESET <= 1'b0;
      else if (fire)
         INTERNAL_RESET <= 1'b1;
   end

   // cause flag: set wins over software clear
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         watchdog_reset_flag <= 1'b0;
      else if (fire)
         watchdog_reset_flag <= 1'b1;
      else if (RESET_CAUSE_CLEAR)
         watchdog_reset_flag <= 1'b0;
   end

   // cause register carries the flag in its watchdog bit
   always_comb
   begin
      RESET_CAUSE_REG = 8'h00;
      RESET_CAUSE_REG[wdt_pkg::RESET_CAUSE_WDT_BIT] = watchdog_reset_flag;
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------

   // service register reads show the reset value only
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         BUS_RDATA <= 8'h00;
      else if (BUS_RD && BUS_ADDR == wdt_pkg::SERVICE_ADDR)
         BUS_RDATA <= enabled ? wdt_pkg::SERVICE_RESET_ENABLED :
                      wdt_pkg::SERVICE_RESET_DISABLED;
      else
         BUS_RDATA <= 8'h00;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------

   svc_clear_a: assert property (@(posedge CLK) disable iff (RST)
      svc_ok |=> (count == 18'h00000) && first_done)
      else $error("service write did not clear counter");

   bad_code_a: assert property (@(posedge CLK) disable iff (RST)
      (svc_hit && BUS_WDATA != wdt_pkg::SERVICE_CODE && !source_stopped)
      |=> INTERNAL_RESET)
      else $error("wrong code did not reset");

   bit_write_a: assert property (@(posedge CLK) disable iff (RST)
      (svc_hit && BUS_BITOP && !source_stopped) |=> INTERNAL_RESET)
      else $error("bit instruction did not reset");

   stopped_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (fault_now && source_stopped && !INTERNAL_RESET && !tick)
      |=> !INTERNAL_RESET && pending)
      else $error("fault not held while source stopped");

   read_value_a: assert property (@(posedge CLK) disable iff (RST)
      (BUS_RD && BUS_ADDR == wdt_pkg::SERVICE_ADDR)
      |=> BUS_RDATA == ($past(enabled) ? 8'h9a : 8'h1a))
      else $error("service read value wrong");

   disabled_quiet_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(INTERNAL_RESET) |-> $past(enabled))
      else $error("reset raised while disabled");

   closed_window_a: assert property (@(posedge CLK) disable iff (RST)
      (svc_hit && first_done && window_closed && !source_stopped)
      |=> INTERNAL_RESET)
      else $error("closed window write not faulted");

   first_free_a: assert property (@(posedge CLK) disable iff (RST)
      (svc_hit && !first_done && !BUS_BITOP && BUS_WDATA == wdt_pkg::SERVICE_CODE
       && !fault_now && !overflow && !pending) |=> count == 18'h00000 && !$rose(INTERNAL_RESET))
      else $error("first service refused");

   overflow_reset_a: assert property (@(posedge CLK) disable iff (RST)
      (enabled && tick && count == last_count && !svc_ok) |=> INTERNAL_RESET)
      else $error("overflow did not reset");

   pause_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (source_stopped && !svc_ok && !tick) |=> $stable(count))
      else $error("counter moved while paused");

   cause_flag_a: assert property (@(posedge CLK) disable iff (RST)
      fire |=> RESET_CAUSE_REG[4])
      else $error("cause flag not set");

   reset_sticky_a: assert property (@(posedge CLK) disable iff (RST)
      INTERNAL_RESET |=> INTERNAL_RESET)
      else $error("internal reset dropped");

   access_fault_a: assert property (@(posedge CLK) disable iff (RST)
      (access_fault && !source_stopped) |=> INTERNAL_RESET)
      else $error("illegal access did not reset");

   pending_fire_a: assert property (@(posedge CLK) disable iff (RST)
      (pending && tick) |=> INTERNAL_RESET)
      else $error("held fault not released on tick");

   open_window_a: assert property (@(posedge CLK) disable iff (RST)
      (svc_hit && first_done && !window_closed && !BUS_BITOP &&
       BUS_WDATA == wdt_pkg::SERVICE_CODE) |=> count == 18'h00000)
      else $error("open window service not accepted");

   cause_clear_a: assert property (@(posedge CLK) disable iff (RST)
      (RESET_CAUSE_CLEAR && !fire) |=> !RESET_CAUSE_REG[4])
      else $error("cause flag not cleared");

   disabled_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (!enabled && !tick) |=> $stable(count))
      else $error("counter moved while disabled");

   other_read_a: assert property (@(posedge CLK) disable iff (RST)
      (BUS_RD && BUS_ADDR != wdt_pkg::SERVICE_ADDR) |=> BUS_RDATA == 8'h00)
      else $error("other address read not zero");
endmodule
